// ### src/pwlc_pkg.sv
// Constants for the pattern word line control block.
package pwlc_pkg;
    localparam int unsigned word_width = 32;
    localparam int unsigned data_width = 32;
    localparam int unsigned line_two_phase_one_level = 15;
    localparam int unsigned line_three_phase_two_level = 16;
    localparam int unsigned line_three_phase_one_level = 17;
    localparam int unsigned line_four_or_sample_edge_bit = 18;
    localparam logic line_reset_level = 1'h1;
    localparam logic [31:0] word_reset_value = 32'hffffffff;
    localparam logic [31:0] data_reset_value = 32'h00000000;
    localparam logic edge_select_reset = 1'h0;
    localparam logic phase_reset_level = 1'h0;
endpackage : pwlc_pkg

// ### src/pwlc_edge_detect.sv
// Edge detector for one synchronous phase clock level; rise and fall compare the live level with a registered copy.
`timescale 1ns/1ps
`default_nettype none
module pwlc_edge_detect #(
    parameter logic reset_level = 1'h0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev <= reset_level;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule : pwlc_edge_detect
`default_nettype wire

// ### src/pwlc_top.sv
// Control line drive and read sampling edge selection from the current pattern word.
//
// Operation
// - Word bit 15 sets control line two level at first phase trailing edge.
// - Word bit 16 sets control line three level at second phase trailing edge.
// - Word bit 17 sets control line three level at first phase trailing edge.
// - Disable clear: bit 18 sets control line four at second phase trailing edge.
// - Disable set during reads: bit 18 picks falling (1) or rising (0) sampling edge.
`timescale 1ns/1ps
`default_nettype none
module pwlc_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic first_phase_clock,
    input wire logic second_phase_clock,
    input wire logic word_valid,
    input wire logic [31:0] pattern_word,
    input wire logic line_four_disable,
    input wire logic read_active,
    input wire logic [31:0] data_bus,
    output logic general_control_line_two,
    output logic general_control_line_three,
    output logic general_control_line_four,
    output logic sample_edge_falling,
    output logic [31:0] read_data,
    output logic read_data_strobe
);
    logic [31:0] current_word;
    logic [31:0] word_now;
    logic p1_rise;
    logic p1_fall;
    logic p2_rise;
    logic p2_fall;
    logic bit_line_two_p1;
    logic bit_line_three_p2;
    logic bit_line_three_p1;
    logic bit_four_or_edge;
    logic line_two_load;
    logic line_three_from_two;
    logic line_three_from_one;
    logic line_four_load;
    logic sample_on_fall;
    logic sample_on_rise;
    logic next_sample_edge;
    logic [31:0] next_read_data;
    logic next_strobe;
    logic sample_mode;
    logic sample_now;
    logic next_line_two;
    logic next_line_three;
    logic next_line_four;

    pwlc_edge_detect #(
        .reset_level(pwlc_pkg::phase_reset_level)
    ) u_phase_one (
        .clk(clk),
        .nrst(nrst),
        .level(first_phase_clock),
        .rise(p1_rise),
        .fall(p1_fall)
    );

    pwlc_edge_detect #(
        .reset_level(pwlc_pkg::phase_reset_level)
    ) u_phase_two (
        .clk(clk),
        .nrst(nrst),
        .level(second_phase_clock),
        .rise(p2_rise),
        .fall(p2_fall)
    );

    // A word presented in the same cycle as an edge is used at once, so a new word
    // never misses the edge that it was loaded for.
    assign word_now = word_valid ? pattern_word : current_word;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            current_word <= pwlc_pkg::word_reset_value;
        end else begin
            current_word <= word_now;
        end
    end

    assign bit_line_two_p1 = word_now[pwlc_pkg::line_two_phase_one_level];
    assign bit_line_three_p2 = word_now[pwlc_pkg::line_three_phase_two_level];
    assign bit_line_three_p1 = word_now[pwlc_pkg::line_three_phase_one_level];
    assign bit_four_or_edge = word_now[pwlc_pkg::line_four_or_sample_edge_bit];

    assign line_two_load = p1_fall;
    assign line_three_from_two = p2_fall;

    // Phase two takes priority if both trailing edges meet in one cycle; the phases
    // never overlap in normal use, so this only settles a malformed input.
    assign line_three_from_one = p1_fall & ~p2_fall;

    // With the disable set, line four holds its last level; bit 18 means an edge instead.
    assign line_four_load = p2_fall & ~line_four_disable;

    assign next_line_two = line_two_load ? bit_line_two_p1 : general_control_line_two;
    assign next_line_three = line_three_from_two ? bit_line_three_p2 :
                             line_three_from_one ? bit_line_three_p1 :
                             general_control_line_three;
    assign next_line_four = line_four_load ? bit_four_or_edge :
                            general_control_line_four;

    // The edge choice stays visible for as long as a read runs with the disable set,
    // even between samples, so that the bus side can steer its own capture timing.
    assign sample_mode = line_four_disable & read_active;
    assign sample_on_fall = sample_mode & bit_four_or_edge & p2_fall;
    assign sample_on_rise = sample_mode & ~bit_four_or_edge & p2_rise;
    assign sample_now = sample_on_fall | sample_on_rise;
    assign next_sample_edge = sample_mode ? bit_four_or_edge : sample_edge_falling;

    // Data are taken at the system clock edge on which the phase edge is first seen,
    // so the phase clocks must stay slow against the system clock.
    assign next_read_data = sample_now ? data_bus : read_data;
    assign next_strobe = sample_now;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            general_control_line_two <= pwlc_pkg::line_reset_level;
        end else begin
            general_control_line_two <= next_line_two;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            general_control_line_three <= pwlc_pkg::line_reset_level;
        end else begin
            general_control_line_three <= next_line_three;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            general_control_line_four <= pwlc_pkg::line_reset_level;
        end else begin
            general_control_line_four <= next_line_four;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sample_edge_falling <= pwlc_pkg::edge_select_reset;
        end else begin
            sample_edge_falling <= next_sample_edge;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            read_data <= pwlc_pkg::data_reset_value;
        end else begin
            read_data <= next_read_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            read_data_strobe <= 1'h0;
        end else begin
            read_data_strobe <= next_strobe;
        end
    end
endmodule : pwlc_top
`default_nettype wire

// ### tb/pwlc_properties.sv
// Port checker for the control lines.
`timescale 1ns/1ps
`default_nettype none
module pwlc_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic first_phase_clock,
    input wire logic second_phase_clock,
    input wire logic word_valid,
    input wire logic [31:0] pattern_word,
    input wire logic line_four_disable,
    input wire logic read_active,
    input wire logic general_control_line_two,
    input wire logic general_control_line_three,
    input wire logic general_control_line_four,
    input wire logic sample_edge_falling,
    input wire logic [31:0] data_bus,
    input wire logic [31:0] read_data,
    input wire logic read_data_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_line_two_one: assert property ($fell(first_phase_clock) && word_valid
        |=> general_control_line_two == $past(pattern_word[15])) else $error("line two");
    chk_line_three_two: assert property ($fell(second_phase_clock) && word_valid
        |=> general_control_line_three == $past(pattern_word[16])) else $error("line three");
    chk_line_three_one: assert property ($fell(first_phase_clock) && word_valid
        && !$fell(second_phase_clock) |=> general_control_line_three == $past(pattern_word[17]))
        else $error("line three");
    chk_line_four_two: assert property ($fell(second_phase_clock) && word_valid
        && !line_four_disable |=> general_control_line_four == $past(pattern_word[18]))
        else $error("line four");
    chk_sample_edge: assert property (line_four_disable && read_active && word_valid
        |=> sample_edge_falling == $past(pattern_word[18])) else $error("sample edge");
    chk_sample_fall_data: assert property (line_four_disable && read_active && word_valid
        && pattern_word[18] && $fell(second_phase_clock)
        |=> read_data_strobe && read_data == $past(data_bus)) else $error("falling sample");
    chk_sample_rise_data: assert property (line_four_disable && read_active && word_valid
        && !pattern_word[18] && $rose(second_phase_clock)
        |=> read_data_strobe && read_data == $past(data_bus)) else $error("rising sample");
    chk_no_sample_idle: assert property (!(line_four_disable && read_active)
        |=> !read_data_strobe) else $error("stray sample strobe");
endmodule : pwlc_properties
bind pwlc_top pwlc_properties chk (.*);
`default_nettype wire

// ### tb/pwlc_mem_model.sv
// Memory side model driving read data.
`timescale 1ns/1ps
`default_nettype none
module pwlc_mem_model (
    input wire logic clk,
    output logic [31:0] data_bus
);
    // Data changes every cycle so stale capture cannot pass.
    initial data_bus = 32'h0;
    always @(posedge clk) data_bus <= #5 {data_bus[30:0], ~data_bus[31]} ^ 32'h5;
endmodule : pwlc_mem_model
`default_nettype wire

// ### tb/tb_top.sv
// Random bench with queued expected line levels.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, nrst, first_phase_clock, second_phase_clock, word_valid, line_four_disable;
    logic read_active, general_control_line_two, general_control_line_three, run, p1, p2;
    logic general_control_line_four, sample_edge_falling, read_data_strobe;
    logic [31:0] pattern_word, data_bus, read_data, rng, w;
    logic [36:0] e, q[$];
    int miscompares, total_checks;
    wire [36:0] seen = {general_control_line_four, general_control_line_three,
        general_control_line_two, sample_edge_falling, read_data_strobe, read_data};
    pwlc_top DUT (.*);
    pwlc_mem_model mem (.clk(clk), .data_bus(data_bus));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction : xs
    task automatic check(input logic [36:0] got, input logic [36:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // Phase two is applied last so it wins line three when both phases end together.
    always @(posedge clk) begin
        if (run) begin
            w = word_valid ? pattern_word : w;
            if (p1 && !first_phase_clock) e[35:34] = {w[17], w[15]};
            if (p2 && !second_phase_clock) e[35] = w[16];
            if (p2 && !second_phase_clock && !line_four_disable) e[36] = w[18];
            if (line_four_disable && read_active) e[33] = w[18];
            e[32] = line_four_disable && read_active
                && (w[18] ? (p2 && !second_phase_clock) : (!p2 && second_phase_clock));
            if (e[32]) e[31:0] = data_bus;
            {p1, p2} = {first_phase_clock, second_phase_clock};
            q.push_back(e);
        end
    end
    always @(posedge clk) begin
        #1;
        if (q.size() > 0) check(seen, q.pop_front());
    end
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        rng = 32'h95a3549a;
        for (int t = 0; t < 2; t++) begin
            {nrst, run, first_phase_clock, second_phase_clock, word_valid} = 5'h0;
            {line_four_disable, read_active, pattern_word} = 34'h0;
            {e, p1, p2, w} = {4'he, 33'h0, 2'h0, 32'hffffffff};
            repeat (2) @(posedge clk);
            #5 nrst = 1'h1;
            run = 1'h1;
            repeat (300) begin
                @(posedge clk);
                #5 rng = xs(rng);
                {first_phase_clock, second_phase_clock, word_valid} = rng[2:0];
                {line_four_disable, read_active} = rng[4:3];
                pattern_word = xs(rng ^ 32'h1);
            end
            @(posedge clk);
            #5 run = 1'h0;
            $display("test %0d done", t);
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
